// ===== rtcsc_pkg.sv
// rtcsc_pkg: offsets, field positions, reset values, carriers and states
// for the sub-second, shift, timestamp and calibration register block.
// assumes a 32-bit AXI4-Lite register bus with byte addresses.
package rtcsc_pkg;

   // register byte offsets
   localparam int          AXI_AW     = 8;
   localparam logic [7:0]  OFF_KEY    = 8'h24;
   localparam logic [7:0]  OFF_SSR    = 8'h28;
   localparam logic [7:0]  OFF_SHIFT  = 8'h2c;
   localparam logic [7:0]  OFF_TST    = 8'h30;
   localparam logic [7:0]  OFF_TSD    = 8'h34;
   localparam logic [7:0]  OFF_TSSS   = 8'h38;
   localparam logic [7:0]  OFF_CAL    = 8'h3c;

   // field positions and widths
   localparam int          ADD1_BIT   = 31;
   localparam int          FRAC_W     = 15;
   localparam int          MINUS_W    = 9;
   localparam int          PRE_S_W    = 15;
   localparam int          PRE_A_W    = 7;
   localparam int          SS_W       = 16;

   // unlock key bytes, written in this order
   localparam logic [7:0]  KEY_FIRST  = 8'hca;
   localparam logic [7:0]  KEY_SECOND = 8'h53;

   // calibration: insert period 2^11, masking window 2^20 kernel pulses
   localparam int          INS_LOG    = 11;
   localparam int          WIN_LOG    = 20;

   // reset values and bus response codes
   localparam logic [15:0] SS_RST     = 16'h0000;
   localparam logic [31:0] REG_RST    = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY  = 2'b00;
   localparam logic [1:0]  RESP_SLV   = 2'b10;

   typedef struct packed {
      logic       pm;
      logic [1:0] hour_tens;
      logic [3:0] hour_units;
      logic [2:0] minute_tens;
      logic [3:0] minute_units;
      logic [2:0] second_tens;
      logic [3:0] second_units;
   } rtcsc_time_s;

   typedef struct packed {
      logic [2:0] weekday_code;
      logic       month_tens;
      logic [3:0] month_units;
      logic [1:0] date_tens;
      logic [3:0] date_units;
   } rtcsc_date_s;

   typedef struct packed {
      logic               calibration_plus;
      logic               eight_second_window;
      logic               sixteen_second_window;
      logic [MINUS_W-1:0] calibration_minus;
   } rtcsc_cal_s;

   localparam rtcsc_cal_s CAL_RST = '0;

   typedef enum logic [2:0] {
      LK_CLOSED = 3'b001,
      LK_HALF   = 3'b010,
      LK_OPEN   = 3'b100
   } rtcsc_lock_e;

endpackage

// ===== rtcsc_top.sv
// rtcsc_top: prescaler counters with smooth calibration, atomic time
// shift, sub-second shadow, timestamp capture and write protection.
// assumes kernel_tick, timestamp_event and calendar values come from
// logic on aclk; backup_resetn is the backup-domain reset on aclk.
//
// Behaviour
// R1: key register reads as zero whatever was written
// R2: sub-second register shows synchronous prescaler counter in bits 15:0
// R3: fraction elapsed is (reload minus count) over (reload plus one)
// R4: system reset clears sub-second shadow only when shadow bypass off
// R5: count above reload only after a shift; true time one second earlier
// R6: writing one to bit 31 adds a second; bit reads zero
// R7: shift writes ignored while a shift is pending
// R8: fraction field added to down counter, delaying clock; reads zero
// R9: add-second with fraction gives one atomic advance
// R10: fraction write clears the shadow-synchronised flag
// R11: timestamp registers cleared while timestamp flag is clear
// R12: timestamp time packed in BCD at documented positions
// R13: timestamp date packed with weekday and BCD fields
// R14: timestamp event captures prescaler counter into stamp sub-second
// R15: plus bit inserts one kernel pulse every 2048 pulses
// R16: minus field masks that many pulses per 2^20 pulses
// R17: net pulses per 32 s equal 512 times plus minus field
// R18: eight-second window forces minus bits 1:0 to zero
// R19: sixteen-second window forces minus bit 0 to zero
// R20: software never sets sixteen-second window with eight-second set
// R21: shift pending set on shift write, cleared once executed
// R22: shadow-synchronised flag set on each shadow copy
// R23: shift and calibration writes need the unlock key sequence
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module rtcsc_top (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic                          backup_resetn,
   input  wire logic [rtcsc_pkg::AXI_AW-1:0]  awaddr,
   input  wire logic [2:0]                    awprot,
   input  wire logic                          awvalid,
   output logic                               awready,
   input  wire logic [31:0]                   wdata,
   input  wire logic [3:0]                    wstrb,
   input  wire logic                          wvalid,
   output logic                               wready,
   output logic [1:0]                         bresp,
   output logic                               bvalid,
   input  wire logic                          bready,
   input  wire logic [rtcsc_pkg::AXI_AW-1:0]  araddr,
   input  wire logic [2:0]                    arprot,
   input  wire logic                          arvalid,
   output logic                               arready,
   output logic [31:0]                        rdata,
   output logic [1:0]                         rresp,
   output logic                               rvalid,
   input  wire logic                          rready,
   input  wire logic                          kernel_tick,
   input  wire logic [rtcsc_pkg::PRE_A_W-1:0] async_prescaler_reload,
   input  wire logic [rtcsc_pkg::PRE_S_W-1:0] sync_prescaler_reload,
   input  wire logic                          shadow_bypass,
   input  wire logic                          timestamp_event,
   input  wire logic                          timestamp_flag_clear,
   input  wire rtcsc_pkg::rtcsc_time_s        calendar_time,
   input  wire rtcsc_pkg::rtcsc_date_s        calendar_date,
   output logic                               shadow_synced_flag,
   output logic                               shift_pending_flag,
   output logic                               timestamp_flag,
   output logic                               second_tick,
   output logic [rtcsc_pkg::SS_W-1:0]         subsecond_value
);
   import rtcsc_pkg::*;

   logic [AXI_AW-1:0]  aw_addr;
   logic               aw_held;
   logic [31:0]        w_data;
   logic [3:0]         w_strb;
   logic               w_held;
   logic               wr_fire;
   logic [31:0]        wr_word;
   logic               unlocked;
   rtcsc_lock_e        lock_state;
   rtcsc_cal_s         cal;
   logic               add_whole_second;
   logic [FRAC_W-1:0]  fraction_subtract;
   logic               shift_accept;
   logic [19:0]        cal_count;
   logic [19:0]        win_pos;
   logic [19:0]        mask_limit;
   logic               ins_pulse;
   logic               mask_pulse;
   logic [1:0]         pulses;
   logic [PRE_A_W-1:0] apre_cnt;
   logic [7:0]         apre_sum;
   logic               apre_tick;
   logic [SS_W-1:0]    ss;
   logic [SS_W-1:0]    ss_shadow;
   logic               shadow_copy;
   rtcsc_time_s        ts_time;
   rtcsc_date_s        ts_date;
   logic [SS_W-1:0]    ts_ss;

   // merge written bytes over an old word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // write address and data are taken independently
   assign awready = !aw_held && !bvalid;
   assign wready  = !w_held && !bvalid;
   assign wr_fire = aw_held && w_held && !bvalid;
   assign unlocked = (lock_state == LK_OPEN);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (awvalid && awready) begin
         aw_held <= 1'b1;
         aw_addr <= awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= REG_RST;
         w_strb <= 4'h0;
      end else if (wvalid && wready) begin
         w_held <= 1'b1;
         w_data <= wdata;
         w_strb <= wstrb;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   // write response one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         case (aw_addr[7:2])
            OFF_KEY[7:2], OFF_SSR[7:2], OFF_SHIFT[7:2], OFF_TST[7:2],
            OFF_TSD[7:2], OFF_TSSS[7:2], OFF_CAL[7:2]: bresp <= RESP_OKAY;
            default: bresp <= RESP_SLV;
         endcase
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // key sequence state; any other key byte closes the lock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_state <= LK_CLOSED;
      end else if (wr_fire && aw_addr[7:2] == OFF_KEY[7:2] && w_strb[0]) begin
         case (lock_state)
            LK_CLOSED: lock_state <= (w_data[7:0] == KEY_FIRST) ? LK_HALF : LK_CLOSED; // R23
            LK_HALF:   lock_state <= (w_data[7:0] == KEY_SECOND) ? LK_OPEN : LK_CLOSED; // R23
            LK_OPEN:   lock_state <= LK_CLOSED;
            default:   lock_state <= LK_CLOSED;
         endcase
      end
   end

   // written word merged over the old value; only calibration keeps bytes
   assign wr_word = merge((aw_addr[7:2] == OFF_CAL[7:2])
                          ? {16'h0, cal.calibration_plus, cal.eight_second_window,
                             cal.sixteen_second_window, 4'h0, cal.calibration_minus}
                          : REG_RST, w_data, w_strb);

   // calibration register, protected; window bits force low minus bits

   always_ff @(posedge aclk) begin
      if (!backup_resetn) begin
         cal <= CAL_RST;
      end else if (wr_fire && unlocked && aw_addr[7:2] == OFF_CAL[7:2]) begin // R23
         cal.calibration_plus      <= wr_word[15];
         cal.eight_second_window   <= wr_word[14];
         cal.sixteen_second_window <= wr_word[13];
         cal.calibration_minus[8:2] <= wr_word[8:2];
         cal.calibration_minus[1]  <= wr_word[1] && !wr_word[14]; // R18
         cal.calibration_minus[0]  <= wr_word[0] && !wr_word[14] && !wr_word[13]; // R18 R19
      end
   end

   // shift request: accepted only when unlocked and nothing pending
   assign shift_accept = wr_fire && unlocked && !shift_pending_flag // R7 R23
                         && aw_addr[7:2] == OFF_SHIFT[7:2];

   always_ff @(posedge aclk) begin
      if (!backup_resetn) begin
         shift_pending_flag <= 1'b0;
         add_whole_second  <= 1'b0;
         fraction_subtract <= '0;
      end else if (shift_accept) begin
         shift_pending_flag <= 1'b1; // R21
         add_whole_second  <= wr_word[ADD1_BIT];
         fraction_subtract <= wr_word[FRAC_W-1:0];
      end else if (shift_pending_flag && !apre_tick) begin
         shift_pending_flag <= 1'b0; // R21
      end
   end

   // kernel pulse count, one insert per 2^11 and masks per window
   always_ff @(posedge aclk) begin
      if (!backup_resetn) begin
         cal_count <= '0;
      end else if (kernel_tick) begin
         cal_count <= cal_count + 20'h1;
      end
   end

   always_comb begin
      if (cal.eight_second_window) begin
         win_pos    = {2'b00, cal_count[17:0]};
         mask_limit = {13'h0, cal.calibration_minus[8:2]};
      end else if (cal.sixteen_second_window) begin
         win_pos    = {1'b0, cal_count[18:0]};
         mask_limit = {12'h0, cal.calibration_minus[8:1]};
      end else begin
         win_pos    = cal_count[WIN_LOG-1:0];
         mask_limit = {11'h0, cal.calibration_minus};
      end
   end

   assign ins_pulse  = cal.calibration_plus && cal_count[INS_LOG-1:0] == '0; // R15
   assign mask_pulse = win_pos < mask_limit; // R16 R17

   // net pulses this cycle: 0, 1 or 2
   always_comb begin
      if (!kernel_tick) begin
         pulses = 2'd0;
      end else if (ins_pulse && !mask_pulse) begin
         pulses = 2'd2; // R15
      end else if (!ins_pulse && mask_pulse) begin
         pulses = 2'd0; // R16
      end else begin
         pulses = 2'd1;
      end
   end

   // asynchronous prescaler, steps by the calibrated pulse count
   assign apre_sum  = {1'b0, apre_cnt} + {6'h0, pulses};
   assign apre_tick = apre_sum > {1'b0, async_prescaler_reload};

   always_ff @(posedge aclk) begin
      if (!backup_resetn) begin
         apre_cnt <= '0;
      end else if (apre_tick) begin
         apre_cnt <= 7'(apre_sum - {1'b0, async_prescaler_reload} - 8'h1);
      end else begin
         apre_cnt <= apre_sum[PRE_A_W-1:0];
      end
   end

   // synchronous down counter; a pending shift runs on a quiet cycle
   always_ff @(posedge aclk) begin
      if (!backup_resetn) begin
         ss <= SS_RST;
      end else if (apre_tick) begin
         ss <= (ss == '0) ? {1'b0, sync_prescaler_reload} : ss - 16'h1; // R3
      end else if (shift_pending_flag) begin
         ss <= ss + {1'b0, fraction_subtract}; // R8 R5
      end
   end

   // second carry to the calendar, also the add-second shift
   always_ff @(posedge aclk) begin
      if (!backup_resetn) begin
         second_tick <= 1'b0;
      end else begin
         second_tick <= (apre_tick && ss == '0)
                        || (shift_pending_flag && !apre_tick && add_whole_second); // R6 R9
      end
   end

   assign subsecond_value = ss;

   // shadow copy on each prescaler step, held off by shift or bypass
   assign shadow_copy = apre_tick && !shift_pending_flag && !shadow_bypass;

   always_ff @(posedge aclk) begin
      if (!backup_resetn || (!aresetn && !shadow_bypass)) begin // R4
         ss_shadow <= SS_RST;
      end else if (shadow_copy) begin
         ss_shadow <= (ss == '0) ? {1'b0, sync_prescaler_reload} : ss - 16'h1; // R2
      end
   end

   // synchronised flag: set wins over every clear
   always_ff @(posedge aclk) begin
      if (!backup_resetn) begin
         shadow_synced_flag <= 1'b0;
      end else if (shadow_copy) begin
         shadow_synced_flag <= 1'b1; // R22
      end else if (shift_accept || shift_pending_flag || shadow_bypass) begin
         shadow_synced_flag <= 1'b0; // R10
      end
   end

   // timestamp flag: event wins over clear
   always_ff @(posedge aclk) begin
      if (!backup_resetn) begin
         timestamp_flag <= 1'b0;
      end else if (timestamp_event) begin
         timestamp_flag <= 1'b1;
      end else if (timestamp_flag_clear) begin
         timestamp_flag <= 1'b0;
      end
   end

   // captured values, emptied while the flag is clear
   always_ff @(posedge aclk) begin
      if (!backup_resetn) begin
         ts_time <= '0;
         ts_date <= '0;
         ts_ss   <= SS_RST;
      end else if (timestamp_event) begin
         ts_time <= calendar_time; // R12
         ts_date <= calendar_date; // R13
         ts_ss   <= ss; // R14
      end else if (!timestamp_flag || timestamp_flag_clear) begin
         ts_time <= '0; // R11
         ts_date <= '0; // R11
         ts_ss   <= SS_RST; // R11
      end
   end

   // read channel, one read at a time, answer the cycle after taking
   assign arready = !rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= REG_RST;
         rresp  <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rresp  <= RESP_OKAY;
         case (araddr[7:2])
            OFF_KEY[7:2]:   rdata <= REG_RST; // R1
            OFF_SSR[7:2]:   rdata <= {16'h0, shadow_bypass ? ss : ss_shadow}; // R2
            OFF_SHIFT[7:2]: rdata <= REG_RST; // R6 R8
            OFF_TST[7:2]:   rdata <= {9'h0, ts_time.pm, ts_time.hour_tens,
                                      ts_time.hour_units, 1'b0, ts_time.minute_tens,
                                      ts_time.minute_units, 1'b0, ts_time.second_tens,
                                      ts_time.second_units}; // R12
            OFF_TSD[7:2]:   rdata <= {16'h0, ts_date.weekday_code, ts_date.month_tens,
                                      ts_date.month_units, 2'b00, ts_date.date_tens,
                                      ts_date.date_units}; // R13
            OFF_TSSS[7:2]:  rdata <= {16'h0, ts_ss}; // R14
            OFF_CAL[7:2]:   rdata <= {16'h0, cal.calibration_plus,
                                      cal.eight_second_window, cal.sixteen_second_window,
                                      4'h0, cal.calibration_minus};
            default: begin
               rdata <= REG_RST;
               rresp <= RESP_SLV;
            end
         endcase
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // checks on the block's own behaviour
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !backup_resetn);

   a_key_reads_zero: assert property ( // R1
      arvalid && arready && araddr[7:2] == OFF_KEY[7:2] |=> rvalid && rdata == 32'h0)
      else $error("key register read not zero");

   a_shift_sets_pending: assert property ( // R21
      shift_accept |=> shift_pending_flag ##1 (shift_pending_flag || !$past(apre_tick)))
      else $error("shift write did not raise pending");

   a_shift_ignored: assert property ( // R7
      shift_pending_flag && $stable(fraction_subtract) && !apre_tick
         |=> $stable(fraction_subtract) && $stable(add_whole_second))
      else $error("shift fields changed while pending");

   a_shift_executes: assert property ( // R8
      shift_pending_flag && !apre_tick |=> !shift_pending_flag
         && ss == $past(ss) + {1'b0, $past(fraction_subtract)})
      else $error("shift not executed on quiet cycle");

   a_reload_wrap: assert property ( // R3
      apre_tick && ss == '0 |=> ss == {1'b0, $past(sync_prescaler_reload)} && second_tick)
      else $error("counter did not reload with second carry");

   a_stamp_capture: assert property ( // R14
      timestamp_event |=> timestamp_flag && ts_ss == $past(ss))
      else $error("timestamp did not capture counter");

   a_stamp_cleared: assert property ( // R11
      !timestamp_flag && !$past(timestamp_event) |-> ts_time == '0 && ts_date == '0
         && ts_ss == '0)
      else $error("timestamp registers hold data with flag clear");

   a_window_forces: assert property ( // R18
      cal.eight_second_window |-> cal.calibration_minus[1:0] == 2'b00)
      else $error("minus low bits not forced in eight-second window");

   a_fraction_clears: assert property ( // R10
      shift_accept && !shadow_copy |=> !shadow_synced_flag [*2])
      else $error("fraction write did not clear synced flag");

   a_plus_insert: assert property ( // R15
      kernel_tick && cal.calibration_plus && cal_count[INS_LOG-1:0] == '0 && !mask_pulse
         |-> pulses == 2'd2)
      else $error("plus calibration did not insert pulse");

endmodule

// ===== rtc_subsecond_shift_stamp_cal_tb.sv
// rtc_subsecond_shift_stamp_cal_tb: self-checking bench for rtcsc_top.
// assumes rtcsc_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module rtc_subsecond_shift_stamp_cal_tb;
   import rtcsc_pkg::*;

   logic        aclk = 0, aresetn = 0, backup_resetn = 0;
   logic [7:0]  awaddr = '0, araddr = '0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = '0, rdata, rd, r32;
   logic [3:0]  wstrb = 4'hf;
   logic [1:0]  bresp, rresp, rr;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        kernel_tick = 0, shadow_bypass = 1, timestamp_event = 0, timestamp_flag_clear = 0;
   logic [14:0] sync_prescaler_reload = 15'h00ff;
   rtcsc_time_s tm = '0;
   rtcsc_date_s cdate = '0;
   logic        shadow_synced_flag, shift_pending_flag, timestamp_flag, second_tick;
   logic [15:0] subsecond_value;
   int          fail_count = 0, n_tests = 0, sec_cnt = 0, pend_cnt = 0, m_ss = 0, f, s0, p0;

   rtcsc_top DUT (.aclk(aclk), .aresetn(aresetn), .backup_resetn(backup_resetn),
      .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .kernel_tick(kernel_tick), .async_prescaler_reload(7'h00),
      .sync_prescaler_reload(sync_prescaler_reload), .shadow_bypass(shadow_bypass),
      .timestamp_event(timestamp_event), .timestamp_flag_clear(timestamp_flag_clear),
      .calendar_time(tm), .calendar_date(cdate), .shadow_synced_flag(shadow_synced_flag),
      .shift_pending_flag(shift_pending_flag), .timestamp_flag(timestamp_flag),
      .second_tick(second_tick), .subsecond_value(subsecond_value));

   // 200 mhz clock
   always #2.5 aclk = ~aclk;

   // count carries to the calendar and cycles with a shift pending
   always @(posedge aclk) begin
      if (second_tick === 1'b1) sec_cnt++;
      if (shift_pending_flag === 1'b1) pend_cnt++;
   end

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %0t value %h expected %h", $time, s, e);
      end
   endtask

   task automatic tmo(input int n);
      if (n >= 50) begin
         fail_count++;
         $display("[ERR] %0t bus answer timed out", $time);
         report_and_stop();
      end
   endtask

   // one axi4-lite write, address and data offered together
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 50);
      rr = bresp;
      bready <= 1'b0;
      tmo(n);
   endtask

   // one axi4-lite read
   task automatic axr(input logic [7:0] a);
      int n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
      tmo(n);
   endtask

   // kernel pulses; the model counter counts down and reloads under zero
   task automatic tick(input int k);
      repeat (k) begin
         @(posedge aclk);
         kernel_tick <= 1'b1;
         @(posedge aclk);
         kernel_tick <= 1'b0;
         m_ss = (m_ss == 0) ? int'(sync_prescaler_reload) : m_ss - 1;
      end
   endtask

   task automatic rst(input logic sys, input logic bkp);
      @(posedge aclk);
      aresetn       <= !sys;
      backup_resetn <= !bkp;
      repeat (2) @(posedge aclk);
      aresetn       <= 1'b1;
      backup_resetn <= 1'b1;
      if (bkp) m_ss = 0;
   endtask

   task automatic unlock;
      axw(OFF_KEY, 32'(KEY_FIRST));
      axw(OFF_KEY, 32'(KEY_SECOND));
   endtask

   // calibration readback model: windows force the low minus bits
   function automatic logic [31:0] cal_exp(input logic [31:0] d);
      logic [31:0] e;
      e = d & 32'h0000_e1ff;
      if (e[14]) e[1:0] = 2'b00;
      else if (e[13]) e[0] = 1'b0;
      return e;
   endfunction

   initial begin
      void'($urandom(32'hbace));
      repeat (20) @(posedge aclk);
      aresetn       <= 1'b1;
      backup_resetn <= 1'b1;
      // reset values, key readback, unmapped offset
      axw(OFF_KEY, 32'h0000_00a5);
      axr(OFF_KEY);
      chk(rd, 32'h0);
      for (int a = 8'h28; a <= 8'h3c; a += 4) begin
         axr(a[7:0]);
         chk(rd, REG_RST);
      end
      axr(8'h40);
      chk({30'h0, rr}, {30'h0, RESP_SLV});
      $display("test reset_map done");
      // calibration: locked write lost, then every window mode
      axw(OFF_CAL, 32'h0000_8001);
      axr(OFF_CAL);
      chk(rd, 32'h0);
      unlock();
      for (int i = 0; i < 4; i++) begin
         f = ($urandom & 32'h01ff) | ((i == 0) ? 0 : (1 << (16 - i)));
         axw(OFF_CAL, f);
         axr(OFF_CAL);
         chk(rd, cal_exp(f));
      end
      $display("test calibration done");
      // live sub-second count; one insert at count zero, first f pulses masked
      rst(1'b0, 1'b1);
      f  = $urandom % 4;
      p0 = $urandom % 3;
      axw(OFF_CAL, 32'h8000 | ((p0 == 0) ? 0 : (32'h1000 << p0)) | (f << p0));
      s0 = 3 + $urandom % 40;
      tick(s0);
      m_ss = 0;
      repeat (s0 + 1 - f) m_ss = (m_ss == 0) ? int'(sync_prescaler_reload) : m_ss - 1;
      axr(OFF_SSR);
      chk(rd, m_ss);
      shadow_bypass <= 1'b0;
      tick(2);
      chk(shadow_synced_flag, 1);
      axr(OFF_SSR);
      chk(rd, m_ss);
      $display("test subsecond done");
      // shift: locked write lost, then add second with fraction
      axw(OFF_KEY, 32'h0);
      p0 = pend_cnt;
      axw(OFF_SHIFT, 32'h0000_0010);
      repeat (4) @(posedge aclk);
      chk(pend_cnt - p0, 0);
      chk(subsecond_value, m_ss);
      chk({30'h0, rr}, {30'h0, RESP_OKAY});
      unlock();
      f  = $urandom & 32'h7fff;
      s0 = sec_cnt;
      p0 = pend_cnt;
      axw(OFF_SHIFT, 32'h8000_0000 | f);
      repeat (4) @(posedge aclk);
      m_ss = (m_ss + f) & 32'hffff;
      chk(subsecond_value, m_ss);
      chk(sec_cnt - s0, 1);
      chk(pend_cnt > p0, 1);
      chk(shift_pending_flag, 0);
      chk(shadow_synced_flag, 0);
      axr(OFF_SHIFT);
      chk(rd, 32'h0);
      $display("test shift done");
      // second shift while one is pending is lost
      rst(1'b0, 1'b1);
      sync_prescaler_reload <= 15'h7fff;
      tick(1);
      repeat (4) @(posedge aclk);
      s0 = sec_cnt;
      kernel_tick <= 1'b1;
      axw(OFF_SHIFT, 32'h8000_0000);
      axw(OFF_SHIFT, 32'h8000_0000);
      chk(shift_pending_flag, 1);
      kernel_tick <= 1'b0;
      repeat (6) @(posedge aclk);
      chk(sec_cnt - s0, 1);
      $display("test pending done");
      // timestamp capture and clear
      rst(1'b0, 1'b1);
      tick(5);
      r32 = $urandom;
      tm <= r32[20:0];
      cdate <= r32[13:0];
      @(posedge aclk);
      timestamp_event <= 1'b1;
      @(posedge aclk);
      timestamp_event <= 1'b0;
      axr(OFF_TST);
      chk(rd, {9'h0, tm.pm, tm.hour_tens, tm.hour_units, 1'b0, tm.minute_tens,
               tm.minute_units, 1'b0, tm.second_tens, tm.second_units});
      axr(OFF_TSD);
      chk(rd, {16'h0, cdate.weekday_code, cdate.month_tens, cdate.month_units, 2'b0,
               cdate.date_tens, cdate.date_units});
      axr(OFF_TSSS);
      chk(rd, m_ss);
      chk(timestamp_flag, 1);
      timestamp_flag_clear <= 1'b1;
      @(posedge aclk);
      timestamp_flag_clear <= 1'b0;
      for (int a = 8'h30; a <= 8'h38; a += 4) begin
         axr(a[7:0]);
         chk(rd, 32'h0);
      end
      chk(timestamp_flag, 0);
      $display("test timestamp done");
      // system reset against the sub-second view
      shadow_bypass <= 1'b1;
      rst(1'b1, 1'b0);
      shadow_bypass <= 1'b0;
      axr(OFF_SSR);
      chk(rd, m_ss);
      shadow_bypass <= 1'b0;
      tick(2);
      rst(1'b1, 1'b0);
      axr(OFF_SSR);
      chk(rd, 32'h0);
      $display("test system_reset done");
      report_and_stop();
   end
endmodule
